// [far_master.sv]
// far-side master model: takes frames, sends speed objects
`timescale 1ns/10ps
module far_master (
	input  wire logic        clk_sys,
	input  wire logic        stall,
	input  wire logic        tx_valid,
	input  wire logic [39:0] tx_frame,
	output logic             tx_ready,
	output logic             rx_valid,
	output logic [2:0]       rx_map,
	output logic [47:0]      rx_speed,
	output logic [39:0]      last_frame,
	output int               frames
);
	// quiet bus until the bench asks for traffic
	initial begin
		tx_ready   = 1'b0;
		rx_valid   = 1'b0;
		rx_map     = 3'h0;
		rx_speed   = 48'h0;
		last_frame = 40'h0;
		frames     = 0;
	end

	// stall holds ready low, so a pending frame must wait
	always @(posedge clk_sys) begin
		tx_ready <= ~stall;
		if (tx_valid && tx_ready) begin
			last_frame <= tx_frame;
			frames     <= frames + 1;
		end
	end

	// unmapped axes go out as zero; idle data lines show garbage
	task automatic send(input logic [2:0] m, input logic [47:0] d);
		@(posedge clk_sys);
		rx_valid <= 1'b1;
		rx_map   <= m;
		rx_speed <= d & {{16{m[2]}}, {16{m[1]}}, {16{m[0]}}};
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		rx_speed <= ~d;
	endtask
endmodule

// [speed_if.sv]
// carrier between the framer and its speed store
`timescale 1ns/10ps
interface speed_if;
	logic        wr;
	logic [2:0]  map;
	logic [47:0] data;
	logic        clear;
	logic [15:0] x;
	logic [15:0] y;
	logic [15:0] z;

	modport store (
		input  wr,
		input  map,
		input  data,
		input  clear,
		output x,
		output y,
		output z
	);
	modport user (
		output wr,
		output map,
		output data,
		output clear,
		input  x,
		input  y,
		input  z
	);
endinterface

// [speed_store.sv]
// holds the latest three-axis speed taken from the receive object
`timescale 1ns/10ps
module speed_store
	import tilt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	speed_if.store   sp
);

	speed_state_type st_q;
	speed_state_type st_d;

	// each mapped component updates alone, unmapped ones keep their value
	always_comb begin
		st_d = st_q;
		if (sp.clear) begin
			st_d = '0;
		end else if (sp.wr) begin
			if (sp.map[0]) st_d.x = sp.data[15:0];
			if (sp.map[1]) st_d.y = sp.data[31:16];
			if (sp.map[2]) st_d.z = sp.data[47:32];
		end
	end

	// update may land on any cycle, no alignment to the transmit cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sp.x = st_q.x;
	assign sp.y = st_q.y;
	assign sp.z = st_q.z;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	AST_SPEED_TAKE: assert property (
		sp.wr && !sp.clear && sp.map[0] |=> sp.x == $past(sp.data[15:0]))
		else $error("mapped speed x not taken");
	AST_SPEED_SUBSET: assert property (
		sp.wr && !sp.clear && !sp.map[1] |=> $stable(sp.y))
		else $error("unmapped speed y changed");
endmodule

// [tb_top.sv]
// self-checking bench for the inclination framer
`timescale 1ns/10ps
`include "tilt_regs.svh"
module tb_top;
	import tilt_pkg::*;
	logic        clk_sys;
	logic        rst;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        sample_valid;
	logic [15:0] incl_long;
	logic [15:0] incl_lat;
	logic [4:0]  flg;
	logic [39:0] tx_frame;
	logic        tx_valid;
	logic        tx_ready;
	logic        rx_valid;
	logic [2:0]  rx_map;
	logic [47:0] rx_speed;
	logic        filter_kalman;
	logic        speed_use;
	logic [15:0] speed_x;
	logic [15:0] speed_y;
	logic [15:0] speed_z;
	logic        irq;
	logic        stall;
	logic [39:0] last_frame;
	int          frames;
	logic [31:0] rv;
	int          failures = 0;
	int          comparisons = 0;

	// short stale timeout keeps the ageing test brief
	tilt_framer #(.SPEED_TIMEOUT_CYCLES(20)) dut (
		.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .sample_valid, .incl_long, .incl_lat,
		.temp_comp_active(~flg[0]), .bias_at_limit(flg[1]),
		.accel_support_needed(flg[2]), .in_motion(flg[3]),
		.severe_error(flg[4]), .tx_frame, .tx_valid, .tx_ready,
		.rx_valid, .rx_map, .rx_speed, .filter_kalman, .speed_use,
		.speed_x, .speed_y, .speed_z, .irq
	);
	far_master p (
		.clk_sys, .stall, .tx_valid, .tx_frame, .tx_ready,
		.rx_valid, .rx_map, .rx_speed, .last_frame, .frames
	);

	// 100 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// bus cycles; the trailing delay lets the write edge land
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask
	task automatic smp(input logic [15:0] lo, input logic [15:0] la,
			input logic [4:0] f);
		@(posedge clk_sys);
		sample_valid <= 1'b1;
		incl_long    <= lo;
		incl_lat     <= la;
		flg          <= f;
		@(posedge clk_sys);
		sample_valid <= 1'b0;
		#1;
	endtask

	// expected status byte: kalman keeps only bits 0 and 4
	function automatic logic [7:0] st(input logic [4:0] f, input logic k);
		return k ? {3'h0, f[4], 3'h0, f[0]} : {3'h0, f};
	endfunction
	function automatic logic [15:0] cl(input logic signed [15:0] v,
			input logic signed [15:0] m);
		return (v > m) ? m : ((v < -m) ? -m : v);
	endfunction

	// main sequence
	initial begin
		logic [15:0] lv [6];
		logic [15:0] av [6];
		logic [39:0] e;
		int          n;
		lv = '{16'h0000, 16'h4650, 16'hB9B0, 16'h4651, 16'h8000, 16'h1267};
		av = '{16'h0000, 16'h2328, 16'hDCD8, 16'h2329, 16'h8001, 16'hF00D};
		rst = 1'b1;
		stall = 1'b0;
		{reg_wr, reg_rd, sample_valid} = 3'h0;
		{incl_long, incl_lat, flg, reg_addr, reg_wdata} = '0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		rd(`REG_CTRL);
		chk(rv, 32'h0);
		rd(8'hFC);
		chk(rv, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			smp(lv[i], av[i], 5'h00);
			e = {8'h00, cl(av[i], 16'sh2328), cl(lv[i], 16'sh4650)};
			chk(tx_frame, e);
		end
		$display("test angles done");
		for (int i = 0; i < 6; i++) begin
			smp(16'h0, 16'h0, (i < 5) ? 5'h01 << i : 5'h1F);
			chk(tx_frame[39:32], st(flg, 1'b0));
			rd(`REG_STATUS);
			chk(rv, {24'h0, st(flg, 1'b0)});
		end
		$display("test flags done");
		wr(`REG_CTRL, 32'h1);
		chk(filter_kalman, 1'b1);
		smp(16'h0, 16'h0, 5'h1F);
		chk(tx_frame[39:32], st(5'h1F, 1'b1));
		p.send(3'h1, 48'h0000_0000_0123);
		@(posedge clk_sys);
		#1;
		chk({speed_use, speed_x}, {1'b1, 16'h0123});
		p.send(3'h2, 48'h0000_FED0_0000);
		@(posedge clk_sys);
		#1;
		chk({speed_y, speed_x}, 32'hFED0_0123);
		rd(`REG_SPEED_X);
		chk(rv, 32'h0123);
		// no refresh: the stored speed must age out
		n = 0;
		while (speed_use === 1'b1 && n < 40) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk(n > 10 && n < 40, 1'b1);
		if (n == 40)
			conclude();
		chk({speed_z, speed_y, speed_x}, 48'h0);
		p.send(3'h7, 48'h0003_0002_0001);
		#1;
		chk({speed_z, speed_y, speed_x}, 48'h0003_0002_0001);
		wr(`REG_CTRL, 32'h0);
		@(posedge clk_sys);
		#1;
		chk({speed_use, speed_x}, 17'h0);
		p.send(3'h1, 48'h0000_0000_0055);
		@(posedge clk_sys);
		#1;
		chk({speed_use, speed_x}, 17'h0);
		rd(`REG_SPEED_X);
		chk(rv, 32'h0);
		$display("test speed done");
		// stalled far side: the later sample replaces the pending one
		rd(`REG_IRQ_STAT);
		chk(rv, 32'hF);
		wr(`REG_IRQ_STAT, 32'hF);
		wr(`REG_IRQ_MASK, 32'h1);
		rd(`REG_IRQ_MASK);
		chk(rv, 32'h1);
		stall <= 1'b1;
		n = frames;
		smp(16'h0100, 16'h0200, 5'h00);
		smp(16'h0300, 16'h0400, 5'h08);
		repeat (3) @(posedge clk_sys);
		#1;
		chk({tx_valid, irq, frames == n}, 3'h5);
		stall <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk({last_frame, irq}, {40'h08_0400_0300, 1'b1});
		wr(`REG_IRQ_STAT, 32'h1);
		@(posedge clk_sys);
		#1;
		chk(irq, 1'b0);
		$display("test irq done");
		conclude();
	end
endmodule

// [tilt_framer.sv]
// inclination transmit framer with speed receive path and register port
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "tilt_regs.svh"
module tilt_framer
	import tilt_pkg::*;
#(
	parameter int unsigned SPEED_TIMEOUT_CYCLES =
		`SPEED_REFRESH_MS * `CLK_KHZ
)
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        sample_valid,
	input  wire logic [15:0] incl_long,
	input  wire logic [15:0] incl_lat,
	input  wire logic        temp_comp_active,
	input  wire logic        bias_at_limit,
	input  wire logic        accel_support_needed,
	input  wire logic        in_motion,
	input  wire logic        severe_error,
	output logic      [39:0] tx_frame,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	input  wire logic        rx_valid,
	input  wire logic [2:0]  rx_map,
	input  wire logic [47:0] rx_speed,
	output logic             filter_kalman,
	output logic             speed_use,
	output logic      [15:0] speed_x,
	output logic      [15:0] speed_y,
	output logic      [15:0] speed_z,
	output logic             irq
);

	framer_state_type s_q;
	framer_state_type s_d;
	speed_if          sp ();

	logic [7:0]  status_byte;
	logic [3:0]  irq_event;
	logic        stale_hit;
	logic        kalman;
	logic [31:0] rd_word;

	// clamp a signed sample into the printed measuring range
	function automatic logic [15:0] clamp(input logic signed [15:0] v,
		input logic signed [15:0] lo, input logic signed [15:0] hi);
		logic [15:0] r;
		r = v;
		if (v > hi) r = hi;
		if (v < lo) r = lo;
		return r;
	endfunction

	assign kalman = (s_q.filter == FILTER_KALMAN);

	// status byte; the kalman layout keeps only temp and severe bits
	always_comb begin
		status_byte = 8'h00;
		status_byte[`ST_TEMP_INACT] = ~temp_comp_active;
		status_byte[`ST_SEVERE]     = severe_error;
		if (!kalman) begin
			status_byte[`ST_BIAS_LIMIT] = bias_at_limit;
			status_byte[`ST_ACCEL_NEED] = accel_support_needed;
			status_byte[`ST_IN_MOTION]  = in_motion;
		end
	end

	// stale speed: partner is expected to refresh well within the timeout
	assign stale_hit = kalman && s_q.speed_live && !rx_valid &&
		(s_q.stale_cnt == SPEED_TIMEOUT_CYCLES - 1);

	// interrupt sources, each a one-cycle event
	always_comb begin
		irq_event = '0;
		irq_event[`IRQ_TX_DONE]     = s_q.tx_valid && tx_ready;
		irq_event[`IRQ_SPEED_RX]    = rx_valid;
		irq_event[`IRQ_SPEED_STALE] = stale_hit;
		irq_event[`IRQ_SEVERE]      = severe_error && !s_q.severe_prev;
	end

	// read decode; unmapped addresses read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (reg_addr)
			`REG_CTRL:     rd_word[`CTRL_FILTER_BIT] = kalman;
			`REG_STATUS:   rd_word = {24'h00_0000, status_byte};
			`REG_IRQ_STAT: rd_word = {28'h000_0000, s_q.irq_stat};
			`REG_IRQ_MASK: rd_word = {28'h000_0000, s_q.irq_mask};
			`REG_SPEED_X:  rd_word = {16'h0000, sp.x};
			`REG_SPEED_Y:  rd_word = {16'h0000, sp.y};
			`REG_SPEED_Z:  rd_word = {16'h0000, sp.z};
			default:       rd_word = 32'h0000_0000;
		endcase
	end

	// next state of the whole framer
	always_comb begin
		s_d = s_q;
		s_d.severe_prev = severe_error;
		s_d.rdata = reg_rd ? rd_word : 32'h0000_0000;
		// a pending frame leaves on ready; a new sample replaces it
		if (s_q.tx_valid && tx_ready) begin
			s_d.tx_valid = 1'b0;
		end
		if (sample_valid) begin
			s_d.frame[`FRM_LONG_LSB +: 16] =
				clamp(incl_long, `LONG_MIN, `LONG_MAX);
			s_d.frame[`FRM_LAT_LSB +: 16] =
				clamp(incl_lat, `LAT_MIN, `LAT_MAX);
			s_d.frame[`FRM_STAT_LSB +: 8] = status_byte;
			s_d.tx_valid = 1'b1;
		end
		// software writes; clear-by-one loses against a same-cycle event
		if (reg_wr) begin
			unique case (reg_addr)
				`REG_CTRL: s_d.filter =
					filter_type'(reg_wdata[`CTRL_FILTER_BIT]);
				`REG_IRQ_STAT: s_d.irq_stat =
					s_q.irq_stat & ~reg_wdata[`IRQ_WIDTH-1:0];
				`REG_IRQ_MASK: s_d.irq_mask = reg_wdata[`IRQ_WIDTH-1:0];
				default: ;
			endcase
		end
		s_d.irq_stat = s_d.irq_stat | irq_event;
		// timeout counter restarts on every speed update
		if (rx_valid) begin
			s_d.stale_cnt  = 32'h0000_0000;
			s_d.speed_live = 1'b1;
		end else if (stale_hit || !kalman) begin
			s_d.stale_cnt  = 32'h0000_0000;
			s_d.speed_live = 1'b0;
		end else if (s_q.speed_live) begin
			s_d.stale_cnt = s_q.stale_cnt + 32'h0000_0001;
		end
	end

	// single register stage for all framer state except the speed values, which the speed store holds
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// speed store is fed straight from the receive object
	assign sp.wr    = rx_valid;
	assign sp.map   = rx_map;
	assign sp.data  = rx_speed;
	assign sp.clear = stale_hit || !kalman;

	speed_store u_speed (
		.clk_sys (clk_sys),
		.rst     (rst),
		.sp      (sp)
	);

	// outputs; speed reaches the fusion only in kalman mode
	assign speed_use     = kalman && s_q.speed_live;
	assign speed_x       = speed_use ? sp.x : 16'h0000;
	assign speed_y       = speed_use ? sp.y : 16'h0000;
	assign speed_z       = speed_use ? sp.z : 16'h0000;
	assign filter_kalman = kalman;
	assign tx_frame      = s_q.frame;
	assign tx_valid      = s_q.tx_valid;
	assign reg_rdata     = s_q.rdata;
	assign irq           = |(s_q.irq_stat & s_q.irq_mask);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	AST_TX_LONG: assert property (
		sample_valid |=> tx_valid &&
		tx_frame[15:0] == $past(clamp(incl_long, `LONG_MIN, `LONG_MAX)))
		else $error("longitudinal bytes wrong");
	AST_TX_LAT: assert property (
		sample_valid |=> $signed(tx_frame[31:16]) <= `LAT_MAX &&
		$signed(tx_frame[31:16]) >= `LAT_MIN &&
		tx_frame[31:16] == $past(clamp(incl_lat, `LAT_MIN, `LAT_MAX)))
		else $error("lateral value wrong or out of range");
	AST_STAT_BYTE: assert property (
		sample_valid && !kalman |=> tx_frame[39:32] == $past({3'b000,
		severe_error, in_motion, accel_support_needed, bias_at_limit,
		~temp_comp_active}))
		else $error("status byte wrong");
	AST_RESERVED: assert property (
		tx_frame[39:37] == 3'b000)
		else $error("reserved status bits set");
	AST_TEMP_INV: assert property (
		sample_valid && temp_comp_active |=> !tx_frame[32])
		else $error("temperature flag not inverse");
	AST_SEVERE: assert property (
		sample_valid && severe_error |=> tx_frame[36])
		else $error("severe error not sent");
	AST_KALMAN_MASK: assert property (
		sample_valid && kalman |=> tx_frame[35:33] == 3'b000)
		else $error("complementary flags leaked in kalman mode");
	AST_SPEED_GATE: assert property (
		!kalman |-> !speed_use && speed_x == 16'h0000 &&
		speed_y == 16'h0000 && speed_z == 16'h0000)
		else $error("speed used outside kalman mode");
	AST_FILTER_SEL: assert property (
		reg_wr && reg_addr == `REG_CTRL |=>
		filter_kalman == $past(reg_wdata[`CTRL_FILTER_BIT]))
		else $error("filter select not taken");
	AST_HOLD: assert property (
		tx_valid && !tx_ready && !sample_valid |=>
		tx_valid && $stable(tx_frame))
		else $error("pending frame lost");
	// a filter write in the same cycle may legally drop the speed
	AST_RX_ANY: assert property (
		rx_valid && kalman && !(reg_wr && reg_addr == `REG_CTRL) |=>
		speed_use)
		else $error("speed update not accepted");
	AST_IRQ_SET: assert property (
		severe_error && !s_q.severe_prev |=> s_q.irq_stat[`IRQ_SEVERE])
		else $error("severe event not latched");

	// out-of-range samples saturate at the range ends
	AST_CLAMP_LONG: assert property (
		sample_valid && $signed(incl_long) > `LONG_MAX |=>
		tx_frame[15:0] == `LONG_MAX)
		else $error("longitudinal not saturated");
	AST_CLAMP_LAT: assert property (
		sample_valid && $signed(incl_lat) < `LAT_MIN |=>
		tx_frame[31:16] == `LAT_MIN)
		else $error("lateral not saturated");

	// kalman layout still carries the temperature and severe bits
	AST_KALMAN_FLAGS: assert property (
		sample_valid && kalman |=>
		tx_frame[36] == $past(severe_error) &&
		tx_frame[32] == !$past(temp_comp_active))
		else $error("kalman status bits wrong");

	// a sent frame leaves and is counted as an event
	AST_TX_LEAVE: assert property (
		tx_valid && tx_ready && !sample_valid |=> !tx_valid)
		else $error("sent frame still pending");
	AST_TX_DONE: assert property (
		tx_valid && tx_ready |=> s_q.irq_stat[`IRQ_TX_DONE])
		else $error("frame sent event not latched");

	// speed events are sticky; clear works only without a new event
	AST_RX_EVENT: assert property (
		rx_valid |=> s_q.irq_stat[`IRQ_SPEED_RX])
		else $error("speed event not latched");
	AST_W1C: assert property (
		reg_wr && reg_addr == `REG_IRQ_STAT &&
		reg_wdata[`IRQ_SPEED_RX] && !rx_valid |=>
		!s_q.irq_stat[`IRQ_SPEED_RX])
		else $error("speed event not cleared");

	// stale or deselected speed must not reach the fusion
	AST_STALE: assert property (
		stale_hit |=> !speed_use && speed_x == 16'h0000 &&
		speed_y == 16'h0000 && speed_z == 16'h0000)
		else $error("stale speed still in use");
	AST_LEAVE_KALMAN: assert property (
		reg_wr && reg_addr == `REG_CTRL &&
		!reg_wdata[`CTRL_FILTER_BIT] |=> ##1
		sp.x == 16'h0000 && sp.y == 16'h0000 && sp.z == 16'h0000)
		else $error("speed store kept outside kalman mode");

	// read port answers once, then returns to zero
	AST_RDATA_IDLE: assert property (
		!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside read cycle");
	AST_RD_STATUS: assert property (
		reg_rd && reg_addr == `REG_STATUS && !kalman |=>
		reg_rdata[7:0] == $past({3'b000, severe_error, in_motion,
		accel_support_needed, bias_at_limit, ~temp_comp_active}))
		else $error("status read wrong");
	AST_RD_CTRL: assert property (
		reg_rd && reg_addr == `REG_CTRL |=>
		reg_rdata == {31'h0000_0000, $past(filter_kalman)})
		else $error("filter read wrong");
endmodule

// [tilt_pkg.sv]
// types shared by the inclination framer
package tilt_pkg;

	typedef enum logic {
		FILTER_COMPL,
		FILTER_KALMAN
	} filter_type;

	typedef struct packed {
		logic [39:0] frame;
		logic        tx_valid;
		logic [3:0]  irq_stat;
		logic [3:0]  irq_mask;
		filter_type  filter;
		logic [31:0] rdata;
		logic [31:0] stale_cnt;
		logic        speed_live;
		logic        severe_prev;
	} framer_state_type;

	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
	} speed_state_type;

endpackage

// [tilt_regs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef TILT_REGS_SVH
`define TILT_REGS_SVH

// register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STAT    8'h08
`define REG_IRQ_MASK    8'h0C
`define REG_SPEED_X     8'h10
`define REG_SPEED_Y     8'h14
`define REG_SPEED_Z     8'h18

// control register fields
`define CTRL_FILTER_BIT 0
`define CTRL_RESET      32'h0000_0000

// interrupt status and mask fields
`define IRQ_TX_DONE     0
`define IRQ_SPEED_RX    1
`define IRQ_SPEED_STALE 2
`define IRQ_SEVERE      3
`define IRQ_WIDTH       4

// status byte fields
`define ST_TEMP_INACT   0
`define ST_BIAS_LIMIT   1
`define ST_ACCEL_NEED   2
`define ST_IN_MOTION    3
`define ST_SEVERE       4

// frame byte layout
`define FRM_LONG_LSB    0
`define FRM_LAT_LSB     16
`define FRM_STAT_LSB    32
`define FRM_WIDTH       40

// angle limits in counts of 0.01 degree
`define LONG_MAX        16'sh4650
`define LONG_MIN        -16'sh4650
`define LAT_MAX         16'sh2328
`define LAT_MIN         -16'sh2328

// timing
`define SPEED_REFRESH_MS 5
`define CLK_KHZ          100000

`endif
